//--- verilog/serial_port_pkg.sv
package serial_port_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] CTRL_IDX = 8'h98;
    localparam logic [7:0] BUF_IDX = 8'h99;
    localparam logic [7:0] PCFG_IDX = 8'h87;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] BUF_RESET = 8'h00;
    // Control register bit positions
    localparam int MODE_HI_BIT = 7;
    localparam int MODE_LO_BIT = 6;
    localparam int MPE_BIT = 5;
    localparam int REN_BIT = 4;
    localparam int TB8_BIT = 3;
    localparam int RB8_BIT = 2;
    localparam int TXDONE_BIT = 1;
    localparam int RXDONE_BIT = 0;
    // Power configuration bit positions
    localparam int DIV_A_BIT = 7;
    localparam int DIV_B_BIT = 6;
    // Modes
    localparam logic [1:0] MODE_SHIFT = 2'h0;
    localparam logic [1:0] MODE_8BIT = 2'h1;
    localparam logic [1:0] MODE_9FIX = 2'h2;
    localparam logic [1:0] MODE_9VAR = 2'h3;
    // Base ticks per bit
    localparam logic [6:0] PER_SHIFT = 7'h0c;
    localparam logic [6:0] PER_FIX_LO = 7'h20;
    localparam logic [6:0] PER_FIX_HI = 7'h40;
    localparam logic [6:0] PER_VAR_64 = 7'h40;
    localparam logic [6:0] PER_VAR_16 = 7'h10;
    localparam logic [6:0] PER_VAR_4 = 7'h04;
    localparam logic [6:0] PER_VAR_2 = 7'h02;
    // Frame lengths in bits, and receive samples after the start bit
    localparam logic [3:0] TX_BITS_SHIFT = 4'h8;
    localparam logic [3:0] TX_BITS_8 = 4'ha;
    localparam logic [3:0] TX_BITS_9 = 4'hb;
    localparam logic [3:0] RX_BITS_SHIFT = 4'h8;
    localparam logic [3:0] RX_BITS_8 = 4'h9;
    localparam logic [3:0] RX_BITS_9 = 4'ha;
    typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} rx_state_t;
endpackage

//--- verilog/serial_bit_timer.sv
module serial_bit_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic tick_i,
    input wire logic [6:0] period_i,
    output logic half_o,
    output logic full_o
);
    typedef struct packed {
        logic [6:0] cnt;
    } timer_t;
    timer_t s;
    timer_t next_s;
    logic [6:0] half_point;

    assign half_point = {1'b0, period_i[6:1]} - 7'h01;
    assign half_o = run_i && tick_i && (s.cnt == half_point);
    assign full_o = run_i && tick_i && (s.cnt == period_i - 7'h01);

    always_comb begin
        next_s = s;
        // Held at zero between frames so every frame starts a fresh bit
        if (!run_i) begin
            next_s.cnt = 7'h00;
        end else if (full_o) begin
            next_s.cnt = 7'h00;
        end else if (tick_i) begin
            next_s.cnt = s.cnt + 7'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule // serial_bit_timer

//--- verilog/serial_port_four_mode.sv
module serial_port_four_mode (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [3:0] byteenable_i,
    input wire logic [31:0] writedata_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    input wire logic timer1_overflow_i,
    input wire logic rx_data_i,
    output logic rx_data_o,
    output logic rx_data_oe_o,
    output logic serial_out_pin_o
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic div_sel_a;
        logic div_sel_b;
        logic [7:0] rx_buf;
        logic waitreq;
        logic [31:0] rdata;
        serial_port_pkg::tx_state_t tx_st;
        logic [10:0] tx_sh;
        logic [3:0] tx_cnt;
        serial_port_pkg::rx_state_t rx_st;
        logic [9:0] rx_sh;
        logic [3:0] rx_cnt;
        logic sclk;
        logic pin;
        logic dout;
        logic doe;
        logic [2:0] sync;
    } state_t;
    state_t s;
    state_t next_s;

    logic [1:0] mode;
    logic [6:0] var_period;
    logic [6:0] period;
    logic tick;
    logic line;
    logic line_fall;
    logic tx_half;
    logic tx_full;
    logic rx_half;
    logic rx_full;
    logic rx_bit;
    logic tx_run;
    logic rx_run;
    logic [31:0] rd_mux;
    logic [1:0] timer_run;
    logic [1:0] timer_half;
    logic [1:0] timer_full;

    assign mode = {s.ctrl[serial_port_pkg::MODE_HI_BIT], s.ctrl[serial_port_pkg::MODE_LO_BIT]};
    assign line = s.sync[1];
    assign line_fall = s.sync[2] && !s.sync[1];
    assign tx_run = (s.tx_st == serial_port_pkg::TX_SHIFT);
    assign rx_run = (s.rx_st != serial_port_pkg::RX_IDLE);

    always_comb begin
        case ({s.div_sel_b, s.div_sel_a})
            2'h0: var_period = serial_port_pkg::PER_VAR_64;
            2'h1: var_period = serial_port_pkg::PER_VAR_16;
            2'h2: var_period = serial_port_pkg::PER_VAR_4;
            default: var_period = serial_port_pkg::PER_VAR_2;
        endcase
    end

    // Shift and fixed modes count clocks; variable modes count timer-1 overflows
    always_comb begin
        case (mode)
            serial_port_pkg::MODE_SHIFT: begin
                period = serial_port_pkg::PER_SHIFT;
                tick = 1'b1;
            end
            serial_port_pkg::MODE_9FIX: begin
                if (s.div_sel_a) begin
                    period = serial_port_pkg::PER_FIX_HI;
                end else begin
                    period = serial_port_pkg::PER_FIX_LO;
                end
                tick = 1'b1;
            end
            default: begin
                period = var_period;
                tick = timer1_overflow_i;
            end
        endcase
    end

    // Separate timers keep transmit and receive free of each other
    // Index 0 times the transmitter, index 1 the receiver
    assign timer_run = {rx_run, tx_run};
    assign tx_half = timer_half[0];
    assign tx_full = timer_full[0];
    assign rx_half = timer_half[1];
    assign rx_full = timer_full[1];

    generate
        for (genvar i = 0; i < 2; i++) begin : g_bit_timer
            serial_bit_timer u_timer (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .run_i(timer_run[i]),
                .tick_i(tick),
                .period_i(period),
                .half_o(timer_half[i]),
                .full_o(timer_full[i])
            );
        end
    endgenerate

    // Read data is latched on the request edge, so the address must already stand
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (address_i)
            serial_port_pkg::CTRL_IDX: rd_mux = {24'h00_0000, s.ctrl};
            serial_port_pkg::BUF_IDX: rd_mux = {24'h00_0000, s.rx_buf};
            serial_port_pkg::PCFG_IDX: rd_mux = {24'h00_0000, s.div_sel_a, s.div_sel_b, 6'h00};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_comb begin
        next_s = s;
        rx_bit = 1'b0;
        // Two flops before any use; the third only marks the falling edge
        next_s.sync = {s.sync[1], s.sync[0], rx_data_i};

        // Bus: first cycle latches read data, second cycle completes
        if (s.waitreq) begin
            if (read_i || write_i) begin
                next_s.waitreq = 1'b0;
                next_s.rdata = rd_mux;
            end
        end else begin
            next_s.waitreq = 1'b1;
            if (write_i && byteenable_i[0]) begin
                case (address_i)
                    // Software may set flags here too; hardware sets below win
                    serial_port_pkg::CTRL_IDX: next_s.ctrl = writedata_i[7:0];
                    serial_port_pkg::PCFG_IDX: begin
                        next_s.div_sel_a = writedata_i[serial_port_pkg::DIV_A_BIT];
                        next_s.div_sel_b = writedata_i[serial_port_pkg::DIV_B_BIT];
                    end
                    serial_port_pkg::BUF_IDX: begin
                        // A write mid-frame reloads the transmitter unless tx_full falls in the same cycle
                        next_s.tx_st = serial_port_pkg::TX_SHIFT;
                        case (mode)
                            serial_port_pkg::MODE_SHIFT: begin
                                next_s.tx_sh = {3'h7, writedata_i[7:0]};
                                next_s.tx_cnt = serial_port_pkg::TX_BITS_SHIFT;
                            end
                            serial_port_pkg::MODE_8BIT: begin
                                next_s.tx_sh = {2'h3, writedata_i[7:0], 1'b0};
                                next_s.tx_cnt = serial_port_pkg::TX_BITS_8;
                            end
                            default: begin
                                next_s.tx_sh = {1'b1, s.ctrl[serial_port_pkg::TB8_BIT],
                                    writedata_i[7:0], 1'b0};
                                next_s.tx_cnt = serial_port_pkg::TX_BITS_9;
                            end
                        endcase
                        next_s.sclk = (mode != serial_port_pkg::MODE_SHIFT);
                    end
                    default: ;
                endcase
            end
        end

        // Transmitter
        case (s.tx_st)
            serial_port_pkg::TX_SHIFT: begin
                if (tx_half && mode == serial_port_pkg::MODE_SHIFT) begin
                    next_s.sclk = 1'b1;
                end
                if (tx_full) begin
                    next_s.tx_sh = {1'b1, s.tx_sh[10:1]};
                    next_s.tx_cnt = s.tx_cnt - 4'h1;
                    // After the last bit the shift clock parks high
                    next_s.sclk = (mode != serial_port_pkg::MODE_SHIFT) || (s.tx_cnt == 4'h1);
                    if (s.tx_cnt == 4'h1) begin
                        next_s.tx_st = serial_port_pkg::TX_IDLE;
                        next_s.ctrl[serial_port_pkg::TXDONE_BIT] = 1'b1;
                    end
                end
            end
            default: ;
        endcase

        // Receiver
        case (s.rx_st)
            serial_port_pkg::RX_IDLE: begin
                if (s.ctrl[serial_port_pkg::REN_BIT]) begin
                    if (mode == serial_port_pkg::MODE_SHIFT) begin
                        // Shift reception waits for an idle transmitter: both share the clock pin
                        if (!s.ctrl[serial_port_pkg::RXDONE_BIT] && !tx_run) begin
                            next_s.rx_st = serial_port_pkg::RX_DATA;
                            next_s.rx_cnt = serial_port_pkg::RX_BITS_SHIFT;
                            next_s.sclk = 1'b0;
                        end
                    end else if (line_fall) begin
                        next_s.rx_st = serial_port_pkg::RX_START;
                        if (mode == serial_port_pkg::MODE_8BIT) begin
                            next_s.rx_cnt = serial_port_pkg::RX_BITS_8;
                        end else begin
                            next_s.rx_cnt = serial_port_pkg::RX_BITS_9;
                        end
                    end
                end
            end
            serial_port_pkg::RX_START: begin
                // A start bit that is gone by mid-bit is a glitch
                if (rx_half && line) begin
                    next_s.rx_st = serial_port_pkg::RX_IDLE;
                end else if (rx_half) begin
                    next_s.rx_st = serial_port_pkg::RX_DATA;
                end
            end
            serial_port_pkg::RX_DATA: begin
                if (mode == serial_port_pkg::MODE_SHIFT) begin
                    // Data is sampled on the rising shift clock
                    if (rx_half) begin
                        next_s.sclk = 1'b1;
                        next_s.rx_sh = {line, s.rx_sh[9:1]};
                        next_s.rx_cnt = s.rx_cnt - 4'h1;
                    end
                    if (rx_full) begin
                        next_s.sclk = 1'b1;
                        if (s.rx_cnt == 4'h0) begin
                            next_s.rx_st = serial_port_pkg::RX_IDLE;
                            rx_bit = 1'b1;
                        end else begin
                            next_s.sclk = 1'b0;
                        end
                    end
                end else if (rx_half) begin
                    next_s.rx_sh = {line, s.rx_sh[9:1]};
                    next_s.rx_cnt = s.rx_cnt - 4'h1;
                    if (s.rx_cnt == 4'h1) begin
                        next_s.rx_st = serial_port_pkg::RX_IDLE;
                        rx_bit = 1'b1;
                    end
                end
            end
            default: next_s.rx_st = serial_port_pkg::RX_IDLE;
        endcase

        // Holding register only loads once the previous character was taken
        if (rx_bit && !s.ctrl[serial_port_pkg::RXDONE_BIT]) begin
            case (mode)
                serial_port_pkg::MODE_SHIFT: begin
                    next_s.rx_buf = next_s.rx_sh[9:2];
                    next_s.ctrl[serial_port_pkg::RXDONE_BIT] = 1'b1;
                end
                serial_port_pkg::MODE_8BIT: begin
                    // Stop bit lands in bit 9, data in bits 8 to 1
                    if (!s.ctrl[serial_port_pkg::MPE_BIT] || next_s.rx_sh[9]) begin
                        next_s.rx_buf = next_s.rx_sh[8:1];
                        next_s.ctrl[serial_port_pkg::RB8_BIT] = next_s.rx_sh[9];
                        next_s.ctrl[serial_port_pkg::RXDONE_BIT] = 1'b1;
                    end
                end
                default: begin
                    // Ninth bit in bit 8; the stop bit in bit 9 is not checked
                    if (!s.ctrl[serial_port_pkg::MPE_BIT] || next_s.rx_sh[8]) begin
                        next_s.rx_buf = next_s.rx_sh[7:0];
                        next_s.ctrl[serial_port_pkg::RB8_BIT] = next_s.rx_sh[8];
                        next_s.ctrl[serial_port_pkg::RXDONE_BIT] = 1'b1;
                    end
                end
            endcase
        end

        // Pins: shift mode puts the clock on the serial output pin
        if (mode == serial_port_pkg::MODE_SHIFT) begin
            next_s.pin = next_s.sclk;
            next_s.doe = (next_s.tx_st == serial_port_pkg::TX_SHIFT);
            next_s.dout = next_s.tx_sh[0];
        end else begin
            if (next_s.tx_st == serial_port_pkg::TX_SHIFT) begin
                next_s.pin = next_s.tx_sh[0];
            end else begin
                next_s.pin = 1'b1;
            end
            next_s.doe = 1'b0;
            next_s.dout = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // Idle levels are high so that release never looks like a start bit
            s <= '0;
            s.ctrl <= serial_port_pkg::CTRL_RESET;
            s.rx_buf <= serial_port_pkg::BUF_RESET;
            s.waitreq <= 1'b1;
            s.tx_sh <= 11'h7ff;
            s.sclk <= 1'b1;
            s.pin <= 1'b1;
            s.dout <= 1'b1;
            s.sync <= 3'h7;
        end else begin
            s <= next_s;
        end
    end

    assign readdata_o = s.rdata;
    assign waitrequest_o = s.waitreq;
    assign rx_data_o = s.dout;
    assign rx_data_oe_o = s.doe;
    assign serial_out_pin_o = s.pin;
endmodule // serial_port_four_mode

//--- testbench/serial_port_props.sv
module serial_port_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [3:0] byteenable_i,
    input wire logic [31:0] writedata_i,
    input wire logic [31:0] readdata_o,
    input wire logic waitrequest_o,
    input wire logic timer1_overflow_i,
    input wire logic rx_data_i,
    input wire logic rx_data_o,
    input wire logic rx_data_oe_o,
    input wire logic serial_out_pin_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_wait_answer: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
        else $error("bus request not answered after one cycle");
    a_wait_pulse: assert property (!waitrequest_o |=> waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    a_wait_cause: assert property (!waitrequest_o |-> $past(read_i || write_i))
        else $error("bus answer without a request");
    a_read_upper: assert property (!waitrequest_o |-> readdata_o[31:8] == 24'h000000)
        else $error("upper read data not zero");
    a_start_bit: assert property (write_i && !waitrequest_o && byteenable_i[0]
        && address_i == serial_port_pkg::BUF_IDX |=> !serial_out_pin_o)
        else $error("buffer write did not start a frame");
    a_data_idle: assert property (!rx_data_oe_o |-> rx_data_o)
        else $error("data pin output not high while released");
    a_shift_low: assert property ($fell(serial_out_pin_o) && rx_data_oe_o
        |-> !serial_out_pin_o [*6] ##1 serial_out_pin_o)
        else $error("shift clock low phase not six cycles");
    a_shift_data: assert property (rx_data_oe_o && $past(rx_data_oe_o) && $changed(rx_data_o)
        |-> $fell(serial_out_pin_o))
        else $error("shift data changed away from falling clock");
    c_buf_write: cover property (write_i && !waitrequest_o && address_i == serial_port_pkg::BUF_IDX);
    c_shift_clk: cover property ($fell(serial_out_pin_o) && rx_data_oe_o);
    c_read_one: cover property (read_i && !waitrequest_o && readdata_o[0]);
endmodule // serial_port_props

bind serial_port_four_mode serial_port_props u_props (.clk_i(clk_i), .rst_i(rst_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .byteenable_i(byteenable_i), .writedata_i(writedata_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .timer1_overflow_i(timer1_overflow_i),
    .rx_data_i(rx_data_i), .rx_data_o(rx_data_o), .rx_data_oe_o(rx_data_oe_o),
    .serial_out_pin_o(serial_out_pin_o));

//--- testbench/remote_serial.sv
module remote_serial (
    input wire logic clk_i,
    input wire logic line_i,
    output logic line_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial line_o = 1'b1;
    // Frame bits LSB first; ninth bit chosen by caller marks address or data
    task automatic send(input logic [10:0] bits, input int n, input int per);
        for (int i = 0; i < n; i++) begin
            line_o <= bits[i];
            repeat (per) @(posedge clk_i);
        end
        line_o <= 1'b1;
    endtask
    // Mid-bit sampling tolerates the receiver's sync latency
    task automatic capture(input int n, input int per, output logic [10:0] bits, output logic ok);
        int t;
        bits = 11'h000;
        ok = 1'b0;
        for (t = 0; t < 4000 && line_i; t++) @(posedge clk_i);
        if (!line_i) begin
            ok = 1'b1;
            repeat (per / 2) @(posedge clk_i);
            for (int i = 0; i < n; i++) begin
                bits[i] = line_i;
                repeat (per) @(posedge clk_i);
            end
        end
    endtask
endmodule // remote_serial

//--- testbench/serial_port_four_mode_tb.sv
module serial_port_four_mode_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] address_i = 8'h00;
    logic read_i = 1'b0;
    logic write_i = 1'b0;
    logic [3:0] byteenable_i = 4'h1;
    logic [31:0] writedata_i = 32'h00000000;
    logic timer1_overflow_i = 1'b0;
    logic [31:0] readdata_o;
    logic waitrequest_o, rx_data_o, rx_data_oe_o, serial_out_pin_o, far_line, pin_level;
    int failures = 0;
    int comparisons = 0;
    integer seed = 32'h59504122;
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) timer1_overflow_i <= ~timer1_overflow_i;
    assign pin_level = rx_data_oe_o ? rx_data_o : far_line;
    serial_port_four_mode u_dut (.clk_i(clk_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
        .write_i(write_i), .byteenable_i(byteenable_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
        .waitrequest_o(waitrequest_o), .timer1_overflow_i(timer1_overflow_i), .rx_data_i(pin_level),
        .rx_data_o(rx_data_o), .rx_data_oe_o(rx_data_oe_o), .serial_out_pin_o(serial_out_pin_o));
    remote_serial u_far (.clk_i(clk_i), .line_i(serial_out_pin_o), .line_o(far_line));
    task automatic complete_run();
        $display("counts: %0d comparisons, %0d failures", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        @(posedge clk_i);
        address_i <= a;
        writedata_i <= {24'h000000, d};
        read_i <= !wr;
        write_i <= wr;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_i);
            if (waitrequest_o === 1'b0) break;
        end
        q = readdata_o[7:0];
        read_i <= 1'b0;
        write_i <= 1'b0;
        if (n == 20) begin
            failures++;
            complete_run();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask
    // Shift data is taken while the shift clock is high
    task automatic shift_take(output logic [7:0] v);
        int n;
        v = 8'h00;
        for (int i = 0; i < 8; i++) begin
            for (n = 0; n < 400 && serial_out_pin_o !== 1'b0; n++) @(posedge clk_i);
            if (n == 400) begin
                failures++;
                complete_run();
            end
            for (n = 0; n < 400 && serial_out_pin_o !== 1'b1; n++) @(posedge clk_i);
            if (n == 400) begin
                failures++;
                complete_run();
            end
            v[i] = rx_data_o;
        end
    endtask
    function automatic logic [10:0] frame(input logic [7:0] d, input logic [1:0] m, input logic nb);
        if (m == serial_port_pkg::MODE_8BIT) begin
            return {2'b01, d, 1'b0};
        end
        return {1'b1, nb, d, 1'b0};
    endfunction
    // Overflow pulses every second cycle, so one tick is two clocks
    function automatic int bit_per(input logic [1:0] m, input logic [7:0] p);
        if (m == serial_port_pkg::MODE_9FIX) begin
            return p[7] ? 64 : 32;
        end
        case (p[7:6])
            2'b00: return 128;
            2'b10: return 32;
            2'b01: return 8;
            default: return 4;
        endcase
    endfunction
    initial begin
        #5000000;
        failures++;
        complete_run();
    end
    initial begin
        logic [7:0] q, d, t, c;
        logic [10:0] got;
        logic ok, nb;
        int per;
        logic [1:0] md [7] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
        logic [7:0] pc [7] = '{8'h00, 8'h80, 8'h40, 8'hc0, 8'h00, 8'h80, 8'h40};
        logic [7:0] cv [4] = '{8'hb0, 8'hb0, 8'h70, 8'h80};
        logic nn [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
        logic ex [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, serial_port_pkg::CTRL_IDX, 8'h00, q);
        check("ctrl reset", q, serial_port_pkg::CTRL_RESET);
        bus(1'b0, serial_port_pkg::BUF_IDX, 8'h00, q);
        check("buf reset", q, serial_port_pkg::BUF_RESET);
        wr(8'h10, 8'hff);
        bus(1'b0, 8'h10, 8'h00, q);
        check("unmapped", q, 11'h000);
        c = $random(seed);
        c[7:6] = serial_port_pkg::MODE_8BIT;
        c[4] = 1'b0;
        wr(serial_port_pkg::CTRL_IDX, c);
        byteenable_i <= 4'h0;
        wr(serial_port_pkg::CTRL_IDX, 8'h55);
        byteenable_i <= 4'h1;
        bus(1'b0, serial_port_pkg::CTRL_IDX, 8'h00, q);
        check("ctrl rw", q, c);
        $display("register test done");
        for (int k = 0; k < 7; k++) begin
            d = $random(seed);
            t = $random(seed);
            nb = $random(seed);
            per = bit_per(md[k], pc[k]);
            wr(serial_port_pkg::PCFG_IDX, pc[k]);
            wr(serial_port_pkg::CTRL_IDX, {md[k], 2'b01, nb, 3'b000});
            fork
                wr(serial_port_pkg::BUF_IDX, d);
                u_far.capture(md[k] == serial_port_pkg::MODE_8BIT ? 10 : 11, per, got, ok);
                u_far.send(frame(t, md[k], ~nb), md[k] == serial_port_pkg::MODE_8BIT ? 10 : 11, per);
            join
            check("tx start", ok, 1'b1);
            check("tx frame", got, frame(d, md[k], nb));
            bus(1'b0, serial_port_pkg::CTRL_IDX, 8'h00, q);
            check("flags", q[2:0], {md[k] == serial_port_pkg::MODE_8BIT ? 1'b1 : ~nb, 2'b11});
            bus(1'b0, serial_port_pkg::BUF_IDX, 8'h00, q);
            check("rx data", q, t);
            bus(1'b0, serial_port_pkg::CTRL_IDX, 8'h00, q);
            check("flags held", q[1:0], 2'b11);
            wr(serial_port_pkg::CTRL_IDX, 8'h00);
        end
        $display("framing test done");
        wr(serial_port_pkg::PCFG_IDX, 8'hc0);
        for (int k = 0; k < 4; k++) begin
            t = $random(seed);
            per = bit_per(cv[k][7:6], 8'hc0);
            wr(serial_port_pkg::CTRL_IDX, cv[k]);
            got = frame(t, cv[k][7:6], nn[k]);
            if (cv[k][6]) got[9] = 1'b0;
            u_far.send(got, cv[k][6] ? 10 : 11, per);
            bus(1'b0, serial_port_pkg::CTRL_IDX, 8'h00, q);
            check("filtered done", q[0], ex[k]);
            wr(serial_port_pkg::CTRL_IDX, 8'h00);
        end
        $display("filter test done");
        d = $random(seed);
        fork
            wr(serial_port_pkg::BUF_IDX, d);
            shift_take(t);
        join
        check("shift data", t, d);
        repeat (6) @(posedge clk_i);
        bus(1'b0, serial_port_pkg::CTRL_IDX, 8'h00, q);
        check("shift tx done", q[1], 1'b1);
        wr(serial_port_pkg::CTRL_IDX, 8'h10);
        shift_take(t);
        repeat (6) @(posedge clk_i);
        bus(1'b0, serial_port_pkg::BUF_IDX, 8'h00, q);
        check("shift rx", q, 8'hff);
        $display("shift test done");
        complete_run();
    end
endmodule // serial_port_four_mode_tb
